/* File: hdl/mqwps_fifo.sv */
`timescale 1ns/1ps
module mqwps_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // Word storage, indexed by pointer
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr;
    logic [AW-1:0] rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Handshakes and pointer advance
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        // Honest flags straight from occupancy
        in_ready = (count != (AW+1)'(DEPTH));
        out_valid = (count != '0);
        out_data = mem[rd_ptr];
    end

    // Pointer and count registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Data store needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

/* File: hdl/mqwps_sync.sv */
`timescale 1ns/1ps
module mqwps_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    // Three stages; the first feeds only the second
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_level;

    // Accept a change once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
        end
    end

    // Stage and filtered level registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            level <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule

/* File: hdl/mqwps_top.sv */
// Behaviour
// - Flag outputs update on write clock
// - Polled mode steps bus, sync on clock
// - Expansion token driven, sampled on clock
// - Enabled write stores word in queue
// - Queue selection ignores write enable
// - New queue written from second edge
// - Old queue used at select+1 edges
// - Flag bus works without write enable
// - Address bus 8 bits, dual purpose
// - Low five bits pick one of 32
// - Upper three bits must match identity
// - Strobe high captures new write queue
// - Strobed mode: low two bits quadrant
// - Quadrant select ignores bits four-two
// - Direct mode quadrant taken on strobe
`timescale 1ns/1ps
module mqwps_top
    import mqwps_pkg::*;
#(
    parameter logic [mqwps_pkg::DEV_W-1:0] DEV_ID = mqwps_pkg::DEV_ID_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [mqwps_pkg::DATA_W-1:0] write_data,
    input wire logic write_en_n,
    input wire logic [mqwps_pkg::ADDR_W-1:0] write_queue_addr,
    input wire logic write_addr_strobe,
    input wire logic flag_quadrant_strobe,
    input wire logic polled_mode,
    input wire logic expansion_token_in,
    input wire logic [mqwps_pkg::NUM_Q-1:0] queue_drain,
    output logic [mqwps_pkg::FLAG_W-1:0] almost_full_flag_bus,
    output logic almost_full_single,
    output logic full_flag,
    output logic flag_bus_sync,
    output logic expansion_token_out,
    output logic write_ready
);
    import mqwps_pkg::*;

    // Writer-side pins share the write clock, so they are used as sampled;
    // a filter here would swallow one-cycle strobes
    logic [DATA_W-1:0] data_s;
    logic [ADDR_W-1:0] addr_s;
    logic wen_n_s, astb_s, fstb_s, poll_s, tok_in_s;
    logic [NUM_Q-1:0] drain_s;
    assign data_s = write_data;
    assign addr_s = write_queue_addr;
    assign wen_n_s = write_en_n;
    assign astb_s = write_addr_strobe;
    assign fstb_s = flag_quadrant_strobe;
    assign tok_in_s = expansion_token_in;
    assign drain_s = queue_drain;

    // Mode strap is a board-level level, not clocked logic: filter it
    mqwps_sync #(.W(1)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(polled_mode),
        .level(poll_s)
    );

    // Identity match on upper address bits
    logic dev_hit;
    assign dev_hit = (addr_dev(addr_s) == DEV_ID);

    // Queue selection pipeline: captured, then active two edges later
    logic [QNUM_W-1:0] sel_q, next_sel_q; // Captured selection
    logic [QNUM_W-1:0] pend_q, next_pend_q; // One edge after capture
    logic [QNUM_W-1:0] act_q, next_act_q; // Queue writes go to
    logic pend_v, next_pend_v; // Pending stage holds a change
    logic quad_v, next_quad_v; // Change in flight toward active

    // Selection capture and switch timing
    always_comb begin
        next_sel_q = sel_q;
        next_pend_q = pend_q;
        next_act_q = act_q;
        next_pend_v = 1'b0;
        next_quad_v = pend_v;
        // Write enable deliberately absent here
        if (astb_s && dev_hit) begin
            next_sel_q = addr_queue(addr_s);
            next_pend_v = 1'b1;
        end
        // Old queue still active on the select edge and the next
        if (pend_v) begin
            next_pend_q = sel_q;
        end
        // Switch lands so the second edge after select uses it
        if (quad_v) begin
            next_act_q = pend_q;
        end
    end

    // Selection registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_q <= QUEUE_RST;
            pend_q <= QUEUE_RST;
            act_q <= QUEUE_RST;
            pend_v <= 1'b0;
            quad_v <= 1'b0;
        end else begin
            sel_q <= next_sel_q;
            pend_q <= next_pend_q;
            act_q <= next_act_q;
            pend_v <= next_pend_v;
            quad_v <= next_quad_v;
        end
    end

    // Write staging FIFO: queue number travels with the word
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [QNUM_W+DATA_W-1:0] f_out_data;
    // Queue targeted uses the active queue at this edge; quad_v edge
    // means act_q updates now, so steer with the value it takes
    logic [QNUM_W-1:0] wr_target;
    assign wr_target = next_act_q;

    // Back-pressure: a full FIFO drops the enable to the writer
    mqwps_fifo #(.WIDTH(QNUM_W + DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(!wen_n_s),
        .in_ready(f_in_ready),
        .in_data({wr_target, data_s}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // Per-queue occupancy, flip-flop counters
    logic [Q_CNT_W-1:0] q_cnt [NUM_Q];
    logic [Q_CNT_W-1:0] next_q_cnt [NUM_Q];
    logic [NUM_Q-1:0] q_full, q_af;
    logic [NUM_Q-1:0] q_in, q_out; // Word lands, word drained
    logic [QNUM_W-1:0] head_q;
    assign head_q = f_out_data[QNUM_W+DATA_W-1 -: QNUM_W];
    // Drain stalls while the head word's queue is full
    assign f_out_ready = !q_full[head_q];

    // Occupancy update per queue
    genvar g;
    generate
        for (g = 0; g < NUM_Q; g++) begin : g_q
            always_comb begin
                next_q_cnt[g] = q_cnt[g];
                q_full[g] = (q_cnt[g] == Q_CNT_W'(Q_CAP));
                q_af[g] = (q_cnt[g] >= Q_CNT_W'(Q_CAP - AF_MARGIN));
                q_in[g] = f_out_valid && f_out_ready && head_q == QNUM_W'(g);
                // An empty queue can still be drained by the word landing now
                q_out[g] = drain_s[g] && (q_cnt[g] != '0 || q_in[g]);
                // Landing and draining in one cycle cancel, no word is lost
                if (q_in[g] && !q_out[g]) begin
                    next_q_cnt[g] = q_cnt[g] + 1'b1;
                end else if (q_out[g] && !q_in[g]) begin
                    next_q_cnt[g] = q_cnt[g] - 1'b1;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    q_cnt[g] <= '0;
                end else begin
                    q_cnt[g] <= next_q_cnt[g];
                end
            end
        end
    endgenerate

    // Flag-bus quadrant: direct selection or polled stepping
    logic [QUAD_W-1:0] quad, next_quad;
    logic next_sync;
    logic [FLAG_W-1:0] next_bus;
    logic next_af, next_ff, next_tok, next_wready;

    // Flag state, no write enable involved
    always_comb begin
        next_quad = quad;
        next_sync = 1'b0;
        if (poll_s) begin
            next_quad = quad + 1'b1;
            next_sync = (quad == QUAD_W'(NUM_QUAD - 1));
        end else if (fstb_s && dev_hit) begin
            // Bits four to two play no part here
            next_quad = addr_quad(addr_s);
        end
        // Quadrant of the next value drives the bus
        next_bus = ~q_af[next_quad*FLAG_W +: FLAG_W];
        next_af = !q_af[act_q];
        next_ff = !q_full[act_q];
        // Token passes once this device's staging FIFO is idle
        next_tok = tok_in_s && !f_out_valid;
        next_wready = f_in_ready;
    end

    // Output registers, all on the write clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            quad <= QUAD_RST;
            almost_full_flag_bus <= '1;
            almost_full_single <= 1'b1;
            full_flag <= 1'b1;
            flag_bus_sync <= 1'b0;
            expansion_token_out <= 1'b0;
            write_ready <= 1'b0;
        end else begin
            quad <= next_quad;
            almost_full_flag_bus <= next_bus;
            almost_full_single <= next_af;
            full_flag <= next_ff;
            flag_bus_sync <= next_sync;
            expansion_token_out <= next_tok;
            write_ready <= next_wready;
        end
    end
endmodule

/* File: inc/mqwps_pkg.sv */
package mqwps_pkg;
    // Bus widths
    localparam int DATA_W = 36;
    localparam int ADDR_W = 8;
    localparam int QNUM_W = 5;
    localparam int NUM_Q = 32;
    localparam int DEV_LSB = 5;
    localparam int DEV_W = 3;
    localparam int QUAD_W = 2;
    localparam int FLAG_W = 8;
    localparam int NUM_QUAD = 4;
    // Staging FIFO shape
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // Reset values
    localparam logic [QNUM_W-1:0] QUEUE_RST = 5'h00;
    localparam logic [QUAD_W-1:0] QUAD_RST = 2'h0;
    // Device identity on the expansion bus; value arbitrary
    localparam logic [DEV_W-1:0] DEV_ID_DEFAULT = 3'h0;
    // Queue switch pipeline length, in write-clock edges
    localparam int SWITCH_LAG = 2;
    // Almost-full level, words free at or below which a queue is flagged
    localparam int AF_MARGIN = 4;
    // Capacity of each queue in words
    localparam int Q_CAP = 64;
    localparam int Q_CNT_W = 7;

    // Queue-address field decode helpers
    function automatic logic [DEV_W-1:0] addr_dev(input logic [ADDR_W-1:0] a);
        return a[DEV_LSB +: DEV_W];
    endfunction
    function automatic logic [QNUM_W-1:0] addr_queue(input logic [ADDR_W-1:0] a);
        return a[QNUM_W-1:0];
    endfunction
    function automatic logic [QUAD_W-1:0] addr_quad(input logic [ADDR_W-1:0] a);
        return a[QUAD_W-1:0];
    endfunction
endpackage

/* File: tb/mqwps_tb_top.sv */
`timescale 1ns/1ps
module mqwps_tb_top;
    import mqwps_pkg::*;
    localparam logic [2:0] MY_ID = 3'h5; // Arbitrary identity
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic polled_mode = 1'b0;
    logic expansion_token_in = 1'b0;
    logic [NUM_Q-1:0] queue_drain = '0;
    logic [DATA_W-1:0] write_data;
    logic write_en_n;
    logic [ADDR_W-1:0] write_queue_addr;
    logic write_addr_strobe;
    logic flag_quadrant_strobe;
    logic [FLAG_W-1:0] almost_full_flag_bus;
    logic almost_full_single;
    logic full_flag;
    logic flag_bus_sync;
    logic expansion_token_out;
    logic write_ready;
    int n_errors = 0;
    int comparisons = 0;
    int cnt [NUM_Q] = '{default: 0}; // Model words per queue
    int a0 = 0; // Model queue taking writes now
    int a1 = 0; // Model queue after pending switch
    int quad = 0; // Model quadrant shown
    int pulses;
    logic [31:0] r;
    logic [31:0] dm;
    int seed = 32'h4d62b2f4;
    always #5 clk = ~clk;
    mqwps_writer i_wr (.clk(clk), .write_data(write_data), .write_en_n(write_en_n),
        .write_queue_addr(write_queue_addr), .write_addr_strobe(write_addr_strobe),
        .flag_quadrant_strobe(flag_quadrant_strobe));
    mqwps_top #(.DEV_ID(MY_ID)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .write_data(write_data), .write_en_n(write_en_n),
        .write_queue_addr(write_queue_addr), .write_addr_strobe(write_addr_strobe),
        .flag_quadrant_strobe(flag_quadrant_strobe), .polled_mode(polled_mode),
        .expansion_token_in(expansion_token_in), .queue_drain(queue_drain),
        .almost_full_flag_bus(almost_full_flag_bus), .almost_full_single(almost_full_single),
        .full_flag(full_flag), .flag_bus_sync(flag_bus_sync),
        .expansion_token_out(expansion_token_out), .write_ready(write_ready));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Drive one cycle and advance the model; the switch lags two edges
    task automatic t_step(input logic we, input logic sel, input logic qs,
        input logic [7:0] a, input logic [31:0] dmask);
        i_wr.step(we, sel, qs, a, DATA_W'({$random(seed), $random(seed)}));
        queue_drain = dmask;
        if (we && cnt[a0] < Q_CAP) cnt[a0]++;
        for (int i = 0; i < NUM_Q; i++) if (dmask[i] && cnt[i] > 0) cnt[i]--;
        a0 = a1;
        if (sel && a[7:5] == MY_ID) a1 = a[4:0];
        if (qs && !sel && a[7:5] == MY_ID && !polled_mode) quad = a[1:0];
    endtask
    // Long enough for the input pipe and flag update
    task automatic settle;
        repeat (12) t_step(1'b0, 1'b0, 1'b0, 8'h00, '0);
    endtask
    task automatic check_flags;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) e[i] = cnt[quad * 8 + i] < Q_CAP - AF_MARGIN;
        check(almost_full_flag_bus, e);
        check({7'h0, full_flag}, {7'h0, cnt[a0] < Q_CAP});
        check({7'h0, almost_full_single}, {7'h0, cnt[a0] < Q_CAP - AF_MARGIN});
    endtask
    task automatic conclude;
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        settle();
        check_flags();
        check({5'h0, flag_bus_sync, expansion_token_out, write_ready}, 8'h01);
        t_step(1'b0, 1'b1, 1'b0, {MY_ID, 5'h01}, '0);
        settle();
        repeat (58) t_step(1'b1, 1'b0, 1'b0, {MY_ID, 5'h01}, '0);
        // Writes keep flowing across the switch edge
        t_step(1'b1, 1'b1, 1'b0, {MY_ID, 5'h02}, '0);
        repeat (3) t_step(1'b1, 1'b0, 1'b0, {MY_ID, 5'h02}, '0);
        settle();
        check_flags();
        t_step(1'b0, 1'b1, 1'b0, {MY_ID ^ 3'h1, 5'h01}, '0);
        repeat (62) t_step(1'b1, 1'b0, 1'b0, {MY_ID, 5'h02}, '0);
        settle();
        check_flags();
        // Random traffic, never past a full queue
        repeat (400) begin
            r = $random(seed);
            dm = (r[14:12] == 0 && r[19:15] != a0 && r[19:15] != a1) ? 32'h1 << r[19:15] : '0;
            t_step(r[0] && cnt[a0] < Q_CAP, r[5:1] == 0, 1'b0,
                {r[6] ? MY_ID : ~MY_ID, r[11:7]}, dm);
        end
        settle();
        for (int q = 0; q < 4; q++) begin
            t_step(1'b0, 1'b0, 1'b1, {MY_ID, 3'($random(seed)), 2'(q)}, '0);
            settle();
            check_flags();
        end
        t_step(1'b0, 1'b0, 1'b1, {MY_ID ^ 3'h2, 5'h01}, '0);
        settle();
        check_flags();
        polled_mode = 1'b1;
        repeat (8) @(negedge clk);
        pulses = 0;
        repeat (40) @(negedge clk) pulses += flag_bus_sync;
        check(8'(pulses), 8'd10);
        polled_mode = 1'b0;
        settle(); // Mode pin passes a three-stage filter
        t_step(1'b0, 1'b0, 1'b1, {MY_ID, 5'h02}, '0);
        settle();
        check_flags();
        check({7'h0, flag_bus_sync}, 8'h00);
        expansion_token_in = 1'b1;
        settle();
        check({7'h0, expansion_token_out}, 8'h01);
        expansion_token_in = 1'b0;
        settle();
        check({7'h0, expansion_token_out}, 8'h00);
        conclude();
    end
endmodule

/* File: tb/mqwps_top_assertions.sv */
`timescale 1ns/1ps
module mqwps_top_assertions
    import mqwps_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic write_en_n,
    input wire logic write_addr_strobe,
    input wire logic flag_quadrant_strobe,
    input wire logic polled_mode,
    input wire logic expansion_token_in,
    input wire logic [mqwps_pkg::NUM_Q-1:0] queue_drain,
    input wire logic [mqwps_pkg::FLAG_W-1:0] almost_full_flag_bus,
    input wire logic almost_full_single,
    input wire logic full_flag,
    input wire logic flag_bus_sync,
    input wire logic expansion_token_out,
    input wire logic write_ready
);
    import mqwps_pkg::*;
    // One write clock, one reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rst_vals;
        $fell(sys_rst) |-> almost_full_flag_bus == 8'hff && full_flag && almost_full_single
            && !flag_bus_sync && !expansion_token_out;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("flags not at idle after reset");
    property p_sync_gap;
        flag_bus_sync |=> !flag_bus_sync [*3];
    endproperty
    a_sync_gap: assert property (p_sync_gap)
        else $error("sync pulse closer than four edges");
    property p_sync_polled;
        (!polled_mode) [*8] |-> !flag_bus_sync;
    endproperty
    a_sync_polled: assert property (p_sync_polled)
        else $error("sync pulse outside polled mode");
    property p_sync_runs;
        polled_mode [*8] |-> ##[0:3] flag_bus_sync;
    endproperty
    a_sync_runs: assert property (p_sync_runs)
        else $error("polled bus not stepping");
    property p_full_af;
        !full_flag |-> !almost_full_single;
    endproperty
    a_full_af: assert property (p_full_af)
        else $error("full without almost full");
    property p_token_low;
        (!expansion_token_in) [*6] |-> !expansion_token_out;
    endproperty
    a_token_low: assert property (p_token_low)
        else $error("token out without token in");
    property p_ready_up;
        $fell(sys_rst) |-> ##[0:2] write_ready;
    endproperty
    a_ready_up: assert property (p_ready_up)
        else $error("write port not ready after reset");
    property p_flags_idle;
        (write_en_n && !write_addr_strobe && !flag_quadrant_strobe && !polled_mode
            && queue_drain == '0) [*8] |-> $stable(almost_full_flag_bus);
    endproperty
    a_flags_idle: assert property (p_flags_idle)
        else $error("flag bus moved while idle");
endmodule
bind mqwps_top mqwps_top_assertions i_chk (.clk(clk), .sys_rst(sys_rst),
    .write_en_n(write_en_n), .write_addr_strobe(write_addr_strobe),
    .flag_quadrant_strobe(flag_quadrant_strobe), .polled_mode(polled_mode),
    .expansion_token_in(expansion_token_in), .queue_drain(queue_drain),
    .almost_full_flag_bus(almost_full_flag_bus), .almost_full_single(almost_full_single),
    .full_flag(full_flag), .flag_bus_sync(flag_bus_sync),
    .expansion_token_out(expansion_token_out), .write_ready(write_ready));

/* File: tb/mqwps_writer.sv */
`timescale 1ns/1ps
module mqwps_writer
    import mqwps_pkg::*;
(
    input wire logic clk,
    output logic [mqwps_pkg::DATA_W-1:0] write_data,
    output logic write_en_n,
    output logic [mqwps_pkg::ADDR_W-1:0] write_queue_addr,
    output logic write_addr_strobe,
    output logic flag_quadrant_strobe
);
    import mqwps_pkg::*;
    // Idle pins at time zero
    initial begin
        write_data = '0;
        write_en_n = 1'b1;
        write_queue_addr = '0;
        write_addr_strobe = 1'b0;
        flag_quadrant_strobe = 1'b0;
    end
    // One write-clock cycle of upstream traffic, launched off the falling edge
    task automatic step(input logic we, input logic sel, input logic qs,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        write_en_n = !we;
        // Unused data flips so a stale word never looks valid
        write_data = we ? d : ~write_data;
        write_addr_strobe = sel;
        flag_quadrant_strobe = qs && !sel;
        write_queue_addr = a;
    endtask
endmodule
